// >>> rtl/awb_pkg.sv
// Constants for the serial wakeup and baud control block
package awb_pkg;
   localparam int IDX_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_BAUD_HIGH = 8'h70;
   localparam logic [IDX_W-1:0] IDX_BAUD_LOW  = 8'h71;
   localparam logic [IDX_W-1:0] IDX_CTRL_ONE  = 8'h72;
   localparam logic [IDX_W-1:0] IDX_CTRL_TWO  = 8'h73;
   localparam logic [IDX_W-1:0] IDX_STAT_ONE  = 8'h74;
   localparam logic [IDX_W-1:0] IDX_STAT_TWO  = 8'h75;
   localparam logic [IDX_W-1:0] IDX_DATA_HIGH = 8'h76;
   localparam logic [IDX_W-1:0] IDX_DATA_LOW  = 8'h77;
   // Baud high fields
   localparam int BH_TEST  = 7;
   localparam int BH_SPLIT = 6;
   localparam int DIV_W    = 13;
   localparam logic [DIV_W-1:0] DIV_RESET = 13'h0004;
   // Control one fields
   localparam int C1_LOOP = 7;
   localparam int C1_ODRN = 6;
   localparam int C1_M    = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_IDT  = 2;
   localparam int C1_PEN  = 1;
   localparam int C1_PTY  = 0;
   // Control two fields
   localparam int C2_TXEI = 7;
   localparam int C2_TXCI = 6;
   localparam int C2_RXI  = 5;
   localparam int C2_IDLI = 4;
   localparam int C2_TE   = 3;
   localparam int C2_RE   = 2;
   localparam int C2_SLP  = 1;
   localparam int C2_SBK  = 0;
   // Status one fields
   localparam int S_TXE  = 7;
   localparam int S_TXC  = 6;
   localparam int S_RXF  = 5;
   localparam int S_IDLE = 4;
   localparam int S_OR   = 3;
   localparam int S_NSE  = 2;
   localparam int S_FRM  = 1;
   localparam int S_PAR  = 0;
   localparam logic [7:0] STAT_RESET = 8'hC0;
   // Sampling: 16 ticks per bit, majority over ticks 7..9
   localparam logic [3:0] PH_S0   = 4'h7;
   localparam logic [3:0] PH_S2   = 4'h9;
   localparam logic [3:0] PH_LAST = 4'hF;
   localparam logic [3:0] FRAME_8 = 4'hA;
   localparam logic [3:0] FRAME_9 = 4'hB;
   typedef enum logic {TX_IDLE, TX_SHIFT} awb_tx_t;
   typedef enum logic {RX_IDLE, RX_DATA} awb_rx_t;
endpackage

// >>> rtl/awb_serial.sv
// Serial transceiver core with wakeup, idle detect and baud divisor
// Functional notes
// - Sleeping receiver sets no receive flag, including receiver-active.
// - Hardware clears sleep at new message; software may write it clear.
// - Idle-line wakeup: sleeping receiver wakes after one frame of ones.
// - Address-mark wakeup: character with top data bit 1 wakes receiver.
// - Wakeup method bit: 0 idle line, 1 address mark.
// - Short idle type counts ones from after the start bit.
// - Long idle type counts ones only after the stop bit.
// - Thirteen-bit modulus prescaler on crystal clock sets the rate.
// - Baud rate is crystal over 32 over divisor.
// - Divisor may be rewritten anytime and takes effect.
// - Baud test bits work only in special test mode.
// - Loop-back feeds transmitter into receiver, pins disconnected; receiver is fed only with TE and RE both set; TE clear reads the pin, RE clear sees ones.
// - Loop-back with transmitter enabled holds transmit pin high.
// - Open-drain select makes pins open drain when outputs.
// - Word size bit selects 8 or 9 data bits.
// - Parity enable turns parity generation and checking on.
// - Parity type selects even or odd parity.
// - Transmit-empty flag requests interrupt when enabled.
// - Transmit-complete flag requests interrupt when enabled.
// - Receive-full or overrun requests interrupt when enabled.
// - Idle flag requests interrupt when enabled.
// - Flag clears by status read while set, then data access.
//
// The implementer's own choice: the Avalon-MM register port.
module awb_serial
   import awb_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic [9:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest,
   input  wire logic        i_special_test_mode,
   input  wire logic        i_rxd,
   output logic             o_txd,
   output logic             o_txd_oe,
   output logic             o_serial_irq
);
   function automatic logic par_of(input logic [8:0] d, input logic m, input logic pt);
      logic p;
      p = m ? ^d[7:0] : ^d[6:0];
      return p ^ pt;
   endfunction

   // Bus state
   logic            ack_ff, nxt_ack;
   logic [31:0]     rdata_ff, nxt_rdata;
   logic [7:0]      ctrl1_ff, nxt_ctrl1;
   logic [7:0]      ctrl2_ff, nxt_ctrl2;
   logic [DIV_W-1:0] div_ff, nxt_div;
   logic [1:0]      btest_ff, nxt_btest;
   logic [7:0]      stat_ff, nxt_stat;
   logic [7:0]      armed_ff, nxt_armed;
   logic [8:0]      txbuf_ff, nxt_txbuf;
   logic            txfull_ff, nxt_txfull;
   logic [8:0]      rxbuf_ff, nxt_rxbuf;
   // Baud state
   logic [DIV_W-1:0] bcnt_ff, nxt_bcnt;
   logic            half_ff, nxt_half;
   // Transmit state
   awb_tx_t         tx_ff, nxt_tx;
   logic [10:0]     tsh_ff, nxt_tsh;
   logic [3:0]      tbits_ff, nxt_tbits;
   logic [3:0]      tph_ff, nxt_tph;
   logic            te_d_ff, nxt_te_d;
   logic            pre_ff, nxt_pre;
   // Receive state
   logic [1:0]      sync_ff, nxt_sync;
   awb_rx_t         rx_ff, nxt_rx;
   logic [3:0]      rph_ff, nxt_rph;
   logic [3:0]      rbit_ff, nxt_rbit;
   logic [2:0]      smp_ff, nxt_smp;
   logic [9:0]      rsh_ff, nxt_rsh;
   logic            rnoise_ff, nxt_rnoise;
   logic [3:0]      ones_ff, nxt_ones;
   logic            seen_ff, nxt_seen;

   logic [IDX_W-1:0] idx;
   logic            acc, wr_ok, rd_ok, data_acc;
   logic            tick16, tick1, rx_line, tx_line;
   logic            loop_on, sleep, m_bit;
   logic [3:0]      flen;
   logic            bit_val, bit_noise, bit_ev;
   logic [8:0]      rword;
   logic [7:0]      set_f, clr_f, tx_set, rx_set;
   logic            wake_hw;

   assign idx      = i_address[9:2];
   assign acc      = (i_read | i_write) & ~ack_ff;
   assign wr_ok    = i_write & ack_ff & i_byteenable[0];
   assign rd_ok    = i_read & ack_ff;
   assign data_acc = (i_read | i_write) & ack_ff & (idx == IDX_DATA_LOW);
   assign o_waitrequest = (i_read | i_write) & ~ack_ff;
   assign o_readdata    = rdata_ff;
   assign m_bit   = ctrl1_ff[C1_M];
   assign flen    = m_bit ? FRAME_9 : FRAME_8;
   assign sleep   = ctrl2_ff[C2_SLP];
   assign loop_on = ctrl1_ff[C1_LOOP] & ctrl2_ff[C2_TE] & ctrl2_ff[C2_RE];
   assign tx_line = (tx_ff == TX_SHIFT) ? tsh_ff[0] : 1'b1;
   assign rx_line = loop_on ? tx_line : (sync_ff[1] | ~ctrl2_ff[C2_RE]);

   // Pin drive: loop-back holds line high, open drain drives only zero
   always_comb
   begin
      logic bitv;
      bitv = ctrl1_ff[C1_LOOP] ? 1'b1 : tx_line;
      o_txd    = bitv;
      o_txd_oe = ctrl2_ff[C2_TE] & (ctrl1_ff[C1_ODRN] ? ~bitv : 1'b1);
   end

   assign o_serial_irq = (ctrl2_ff[C2_TXEI] & stat_ff[S_TXE])
                       | (ctrl2_ff[C2_TXCI] & stat_ff[S_TXC])
                       | (ctrl2_ff[C2_RXI] & (stat_ff[S_RXF] | stat_ff[S_OR]))
                       | (ctrl2_ff[C2_IDLI] & stat_ff[S_IDLE]);

   // Baud: modulus divide, then by two for sixteen ticks per bit
   always_comb
   begin
      nxt_bcnt = bcnt_ff;
      nxt_half = half_ff;
      tick16   = 1'b0;
      if (div_ff == '0)
      begin
         nxt_bcnt = '0;
      end
      else if (bcnt_ff >= div_ff - 13'h0001)
      begin
         nxt_bcnt = '0;
         nxt_half = ~half_ff;
         tick16   = half_ff;
      end
      else
      begin
         nxt_bcnt = bcnt_ff + 13'h0001;
      end
   end
   assign tick1 = tick16 & (tph_ff == PH_LAST);
   assign set_f = tx_set | rx_set;

   // Transmitter
   always_comb
   begin
      logic [8:0] d;
      nxt_tx    = tx_ff;
      nxt_tsh   = tsh_ff;
      nxt_tbits = tbits_ff;
      nxt_tph   = tick16 ? tph_ff + 4'h1 : tph_ff;
      nxt_te_d  = ctrl2_ff[C2_TE];
      nxt_pre   = pre_ff | (ctrl2_ff[C2_TE] & ~te_d_ff);
      d         = txbuf_ff;
      if (ctrl1_ff[C1_PEN])
      begin
         if (m_bit)
            d[8] = par_of(txbuf_ff, 1'b1, ctrl1_ff[C1_PTY]);
         else
            d[7] = par_of(txbuf_ff, 1'b0, ctrl1_ff[C1_PTY]);
      end
      tx_set = '0;
      if (tick1)
      begin
         unique case (tx_ff)
            TX_IDLE:
            begin
               if (ctrl2_ff[C2_TE] & pre_ff)
               begin
                  nxt_pre   = 1'b0;
                  nxt_tsh   = '1;
                  nxt_tbits = flen;
                  nxt_tx    = TX_SHIFT;
               end
               else if (ctrl2_ff[C2_TE] & ctrl2_ff[C2_SBK])
               begin
                  nxt_tsh   = '0;
                  nxt_tbits = flen;
                  nxt_tx    = TX_SHIFT;
               end
               else if (ctrl2_ff[C2_TE] & txfull_ff)
               begin
                  nxt_tsh   = m_bit ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
                  nxt_tbits = flen;
                  nxt_tx    = TX_SHIFT;
                  tx_set[S_TXE] = 1'b1;
               end
               else
               begin
                  tx_set[S_TXC] = 1'b1;
               end
            end
            TX_SHIFT:
            begin
               nxt_tsh   = {1'b1, tsh_ff[10:1]};
               nxt_tbits = tbits_ff - 4'h1;
               if (tbits_ff == 4'h1)
                  nxt_tx = TX_IDLE;
            end
         endcase
      end
   end

   // Receiver: three-sample majority, frame assembly, idle counting
   always_comb
   begin
      logic frm_bad, par_bad, load, addr;
      nxt_sync   = {sync_ff[0], i_rxd};
      nxt_rx     = rx_ff;
      nxt_rph    = rph_ff;
      nxt_rbit   = rbit_ff;
      nxt_smp    = smp_ff;
      nxt_rsh    = rsh_ff;
      nxt_rnoise = rnoise_ff;
      nxt_ones   = ones_ff;
      nxt_seen   = seen_ff;
      nxt_rxbuf  = rxbuf_ff;
      frm_bad = 1'b0;
      par_bad = 1'b0;
      rx_set  = '0;
      load = 1'b0;
      addr = 1'b0;
      wake_hw = 1'b0;
      bit_val   = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) | (smp_ff[1] & smp_ff[2]);
      bit_noise = ~(&smp_ff) & (|smp_ff);
      bit_ev    = tick16 & (rph_ff == PH_S2 + 4'h1);
      rword     = m_bit ? rsh_ff[9:1] : {1'b0, rsh_ff[9:2]};
      clr_f     = '0;
      if (tick16)
      begin
         nxt_rph = rph_ff + 4'h1;
         if (rph_ff >= PH_S0 && rph_ff <= PH_S2)
            nxt_smp = {smp_ff[1:0], rx_line};
         if (rx_ff == RX_IDLE && !rx_line)
         begin
            nxt_rx     = RX_DATA;
            nxt_rph    = 4'h1;
            nxt_rbit   = '0;
            nxt_rnoise = 1'b0;
         end
      end
      if (bit_ev)
      begin
         if (bit_val && ones_ff != flen)
            nxt_ones = ones_ff + 4'h1;
         else if (!bit_val)
            nxt_ones = '0;
         if (bit_val && ones_ff == flen - 4'h1)
         begin
            if (seen_ff && !sleep)
               rx_set[S_IDLE] = 1'b1;
            nxt_seen = 1'b0;
            if (!ctrl1_ff[C1_WAKE])
               wake_hw = 1'b1;
         end
         if (rx_ff == RX_DATA)
         begin
            nxt_rnoise = rnoise_ff | bit_noise;
            nxt_rbit   = rbit_ff + 4'h1;
            if (rbit_ff == '0)
            begin
               if (bit_val)
                  nxt_rx = RX_IDLE;
               else
                  nxt_seen = 1'b1;
               nxt_ones = '0;
            end
            else if (rbit_ff == flen - 4'h1)
            begin
               nxt_rx = RX_IDLE;
               frm_bad  = ~bit_val;
               nxt_ones = '0;
               if (!ctrl1_ff[C1_IDT] && bit_val)
                  nxt_ones = (ones_ff == flen) ? flen : ones_ff + 4'h1;
               addr = m_bit ? rword[8] : rword[7];
               if (ctrl1_ff[C1_PEN])
                  par_bad = (m_bit ? rword[8] : rword[7])
                          != par_of(rword, m_bit, ctrl1_ff[C1_PTY]);
               load = ~sleep | (ctrl1_ff[C1_WAKE] & addr);
               if (sleep && load)
                  wake_hw = 1'b1;
            end
            else
            begin
               nxt_rsh = {bit_val, rsh_ff[9:1]};
               if (ctrl1_ff[C1_IDT])
                  nxt_ones = '0;
            end
         end
      end
      if (load && !stat_ff[S_FRM])
      begin
         if (stat_ff[S_RXF])
            rx_set[S_OR] = 1'b1;
         else
         begin
            nxt_rxbuf     = rword;
            rx_set[S_RXF] = 1'b1;
            rx_set[S_NSE] = rnoise_ff | bit_noise;
            rx_set[S_FRM] = frm_bad;
            rx_set[S_PAR] = par_bad;
         end
      end
      if (data_acc)
         clr_f = armed_ff;
   end

   // Registers and bus answers
   always_comb
   begin
      nxt_ack    = acc;
      nxt_rdata  = rdata_ff;
      nxt_ctrl1  = ctrl1_ff;
      nxt_ctrl2  = ctrl2_ff;
      nxt_div    = div_ff;
      nxt_btest  = i_special_test_mode ? btest_ff : 2'b00;
      nxt_txbuf  = txbuf_ff;
      nxt_txfull = txfull_ff & ~set_f[S_TXE];
      nxt_armed  = armed_ff & ~clr_f;
      nxt_stat   = (stat_ff & ~clr_f) | set_f;
      if (acc)
      begin
         unique case (idx)
            IDX_BAUD_HIGH: nxt_rdata = {24'h0, btest_ff, 1'b0, div_ff[12:8]};
            IDX_BAUD_LOW:  nxt_rdata = {24'h0, div_ff[7:0]};
            IDX_CTRL_ONE:  nxt_rdata = {24'h0, ctrl1_ff};
            IDX_CTRL_TWO:  nxt_rdata = {24'h0, ctrl2_ff};
            IDX_STAT_ONE:  nxt_rdata = {24'h0, stat_ff};
            IDX_STAT_TWO:  nxt_rdata = {31'h0, (rx_ff == RX_DATA) & ~sleep};
            IDX_DATA_HIGH: nxt_rdata = {24'h0, rxbuf_ff[8], 7'h0};
            IDX_DATA_LOW:  nxt_rdata = {24'h0, rxbuf_ff[7:0]};
            default:       nxt_rdata = 32'h0;
         endcase
      end
      if (rd_ok && idx == IDX_STAT_ONE)
         nxt_armed = stat_ff;
      if (wr_ok)
      begin
         unique case (idx)
            IDX_BAUD_HIGH:
            begin
               nxt_div[12:8] = i_writedata[4:0];
               if (i_special_test_mode)
                  nxt_btest = i_writedata[BH_TEST:BH_SPLIT];
            end
            IDX_BAUD_LOW:  nxt_div[7:0] = i_writedata[7:0];
            IDX_CTRL_ONE:  nxt_ctrl1 = i_writedata[7:0];
            IDX_CTRL_TWO:  nxt_ctrl2 = i_writedata[7:0];
            IDX_DATA_HIGH: nxt_txbuf[8] = i_writedata[7];
            IDX_DATA_LOW:
            begin
               nxt_txbuf[7:0] = i_writedata[7:0];
               nxt_txfull     = 1'b1;
            end
            default: ;
         endcase
      end
      if (wake_hw)
         nxt_ctrl2[C2_SLP] = 1'b0;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         ack_ff    <= 1'b0;
         rdata_ff  <= '0;
         ctrl1_ff  <= '0;
         ctrl2_ff  <= '0;
         div_ff    <= DIV_RESET;
         btest_ff  <= '0;
         stat_ff   <= STAT_RESET;
         armed_ff  <= '0;
         txbuf_ff  <= '0;
         txfull_ff <= 1'b0;
         rxbuf_ff  <= '0;
         bcnt_ff   <= '0;
         half_ff   <= 1'b0;
         tx_ff     <= TX_IDLE;
         tsh_ff    <= '1;
         tbits_ff  <= '0;
         tph_ff    <= '0;
         te_d_ff   <= 1'b0;
         pre_ff    <= 1'b0;
         sync_ff   <= 2'b11;
         rx_ff     <= RX_IDLE;
         rph_ff    <= '0;
         rbit_ff   <= '0;
         smp_ff    <= '1;
         rsh_ff    <= '0;
         rnoise_ff <= 1'b0;
         ones_ff   <= '0;
         seen_ff   <= 1'b0;
      end
      else
      begin
         ack_ff    <= nxt_ack;
         rdata_ff  <= nxt_rdata;
         ctrl1_ff  <= nxt_ctrl1;
         ctrl2_ff  <= nxt_ctrl2;
         div_ff    <= nxt_div;
         btest_ff  <= nxt_btest;
         stat_ff   <= nxt_stat;
         armed_ff  <= nxt_armed;
         txbuf_ff  <= nxt_txbuf;
         txfull_ff <= nxt_txfull;
         rxbuf_ff  <= nxt_rxbuf;
         bcnt_ff   <= nxt_bcnt;
         half_ff   <= nxt_half;
         tx_ff     <= nxt_tx;
         tsh_ff    <= nxt_tsh;
         tbits_ff  <= nxt_tbits;
         tph_ff    <= nxt_tph;
         te_d_ff   <= nxt_te_d;
         pre_ff    <= nxt_pre;
         sync_ff   <= nxt_sync;
         rx_ff     <= nxt_rx;
         rph_ff    <= nxt_rph;
         rbit_ff   <= nxt_rbit;
         smp_ff    <= nxt_smp;
         rsh_ff    <= nxt_rsh;
         rnoise_ff <= nxt_rnoise;
         ones_ff   <= nxt_ones;
         seen_ff   <= nxt_seen;
      end
   end
endmodule

// >>> testbench/awb_checker.sv
// Port-level checker for the serial wakeup and baud control block
module awb_checker
   import awb_pkg::*;
(
   input wire logic        i_clock,
   input wire logic        i_reset,
   input wire logic [9:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0]  i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic        i_special_test_mode,
   input wire logic        i_rxd,
   input wire logic        o_txd,
   input wire logic        o_txd_oe,
   input wire logic        o_serial_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] idx;
   logic       wdone;
   logic       te_ff, loop_ff, odrn_ff, nxt_te, nxt_loop, nxt_odrn;
   logic [3:0] en_ff, nxt_en;

   // Shadow of control bits from completed writes
   always_comb
   begin
      idx = i_address[9:2];
      wdone = i_write && !o_waitrequest && i_byteenable[0];
      nxt_te = te_ff;
      nxt_en = en_ff;
      nxt_loop = loop_ff;
      nxt_odrn = odrn_ff;
      if (wdone && idx == IDX_CTRL_TWO)
      begin
         nxt_te = i_writedata[C2_TE];
         nxt_en = i_writedata[7:4];
      end
      if (wdone && idx == IDX_CTRL_ONE)
      begin
         nxt_loop = i_writedata[C1_LOOP];
         nxt_odrn = i_writedata[C1_ODRN];
      end
      if (i_reset)
      begin
         nxt_te = 1'b0;
         nxt_en = 4'h0;
         nxt_loop = 1'b0;
         nxt_odrn = 1'b0;
      end
   end

   always_ff @(posedge i_clock)
   begin
      te_ff <= nxt_te;
      en_ff <= nxt_en;
      loop_ff <= nxt_loop;
      odrn_ff <= nxt_odrn;
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   sequence s_req_new;
      (i_read || i_write) && o_waitrequest;
   endsequence
   sequence s_read_high;
      i_read && !o_waitrequest && idx == IDX_BAUD_HIGH;
   endsequence

   property p_first_wait;
      $rose(i_read || i_write) |-> o_waitrequest;
   endproperty
   property p_one_wait;
      s_req_new |=> !o_waitrequest;
   endproperty
   property p_idle_wait;
      !(i_read || i_write) |-> !o_waitrequest;
   endproperty
   property p_upper_zero;
      o_readdata[31:8] == 24'h000000;
   endproperty
   property p_test_bits;
      s_read_high and !i_special_test_mode |-> o_readdata[7:5] == 3'h0;
   endproperty
   property p_oe_off;
      !te_ff |-> !o_txd_oe;
   endproperty
   property p_loop_high;
      loop_ff && te_ff |-> o_txd;
   endproperty
   property p_odrain;
      odrn_ff && o_txd_oe |-> !o_txd;
   endproperty
   property p_drive;
      te_ff && !odrn_ff |-> o_txd_oe;
   endproperty
   property p_irq_off;
      en_ff == 4'h0 |-> !o_serial_irq;
   endproperty

   a_first_wait: assert property (p_first_wait) else $error("no wait cycle");
   a_one_wait: assert property (p_one_wait) else $error("wait too long");
   a_idle_wait: assert property (p_idle_wait) else $error("wait while idle");
   a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
   a_test_bits: assert property (p_test_bits) else $error("test bits seen");
   a_oe_off: assert property (p_oe_off) else $error("pin driven, tx off");
   a_loop_high: assert property (p_loop_high) else $error("loop pin low");
   a_odrain: assert property (p_odrain) else $error("open drain high");
   a_drive: assert property (p_drive) else $error("pin not driven");
   a_irq_off: assert property (p_irq_off) else $error("irq unenabled");
endmodule

bind awb_serial awb_checker u_chk (
   .i_clock             (i_clock),
   .i_reset             (i_reset),
   .i_address           (i_address),
   .i_read              (i_read),
   .i_write             (i_write),
   .i_writedata         (i_writedata),
   .i_byteenable        (i_byteenable),
   .o_readdata          (o_readdata),
   .o_waitrequest       (o_waitrequest),
   .i_special_test_mode (i_special_test_mode),
   .i_rxd               (i_rxd),
   .o_txd               (o_txd),
   .o_txd_oe            (o_txd_oe),
   .o_serial_irq        (o_serial_irq)
);

// >>> testbench/awb_line_node.sv
// Far-side serial node on the shared line
module awb_line_node (
   input  wire logic i_clock,
   input  wire logic i_line,
   output logic      o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_cyc = 128;
   initial o_line = 1'b1;

   // Frames follow one another with no gap inside a message
   task automatic send(input logic [8:0] d, input int nb);
      for (int k = 0; k < nb + 2; k++)
      begin
         o_line <= (k == 0) ? 1'b0 : (k > nb) ? 1'b1 : d[k-1];
         repeat (bit_cyc) @(posedge i_clock);
      end
   endtask

   // Capture start, eight data and stop at mid-bit
   task automatic grab(output logic [9:0] f);
      int n;
      n = 0;
      while (i_line !== 1'b0 && n < 20000)
      begin
         @(posedge i_clock);
         n++;
      end
      repeat (bit_cyc / 2) @(posedge i_clock);
      for (int k = 0; k < 10; k++)
      begin
         f[k] = i_line;
         repeat (bit_cyc) @(posedge i_clock);
      end
   endtask
endmodule

// >>> testbench/awb_serial_tb.sv
// Testbench for the serial wakeup and baud control block
module awb_serial_tb
   import awb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  adr = 10'h000;
   logic        rd_r = 1'b0;
   logic        wr_r = 1'b0;
   logic [31:0] wd = 32'h00000000;
   logic        tmode = 1'b0;
   logic        rxd;
   logic [31:0] rdat;
   logic        wait_r, txd, txd_oe, irq;
   wire         line_tx = txd_oe ? txd : 1'b1;
   int          bad_count = 0;
   int          check_count = 0;

   always #12.5 clk = ~clk;

   awb_serial dut (
      .i_clock             (clk),
      .i_reset             (rst),
      .i_address           (adr),
      .i_read              (rd_r),
      .i_write             (wr_r),
      .i_writedata         (wd),
      .i_byteenable        (4'hF),
      .o_readdata          (rdat),
      .o_waitrequest       (wait_r),
      .i_special_test_mode (tmode),
      .i_rxd               (rxd),
      .o_txd               (txd),
      .o_txd_oe            (txd_oe),
      .o_serial_irq        (irq)
   );

   awb_line_node u_node (
      .i_clock (clk),
      .i_line  (line_tx),
      .o_line  (rxd)
   );

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      rd_r <= !w;
      wr_r <= w;
      adr <= {ix, 2'b00};
      wd <= {24'h000000, d};
      do
      begin
         @(posedge clk);
      end
      while (wait_r !== 1'b0);
      q = rdat[7:0];
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, ix, d, q);
   endtask

   task automatic poll(input logic [7:0] ix, input logic [7:0] m, input logic [7:0] want,
                       input int lim, input string nm);
      logic [7:0] q;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, ix, 8'h00, q);
         n++;
      end
      while ((q & m) !== want && n < lim);
      chk(nm, q & m, want);
   endtask

   task automatic irq_is(input logic exp, input string nm);
      @(negedge clk);
      chk(nm, irq, exp);
   endtask

   task automatic t_regs;
      poll(IDX_STAT_ONE, 8'hFF, STAT_RESET, 1, "stat_reset");
      poll(IDX_BAUD_LOW, 8'hFF, DIV_RESET[7:0], 1, "baud_low");
      poll(IDX_BAUD_HIGH, 8'hFF, {3'h0, DIV_RESET[12:8]}, 1, "baud_high");
      poll(8'h10, 8'hFF, 8'h00, 1, "unmapped");
      wr(IDX_BAUD_HIGH, 8'hC0);
      poll(IDX_BAUD_HIGH, 8'hFF, 8'h00, 1, "test_off");
      tmode <= 1'b1;
      wr(IDX_BAUD_HIGH, 8'hC0);
      poll(IDX_BAUD_HIGH, 8'hFF, 8'hC0, 1, "test_on");
      wr(IDX_BAUD_HIGH, 8'h00);
      tmode <= 1'b0;
   endtask

   task automatic t_irq;
      wr(IDX_CTRL_TWO, 8'h80);
      irq_is(1'b1, "irq_empty");
      wr(IDX_CTRL_TWO, 8'h40);
      irq_is(1'b1, "irq_done");
      wr(IDX_CTRL_TWO, 8'h30);
      irq_is(1'b0, "irq_rx_none");
   endtask

   task automatic t_tx;
      logic [9:0] f;
      logic [7:0] d, cfg;
      int dv;
      wr(IDX_CTRL_TWO, 8'h0C);
      for (int k = 0; k < 3; k++)
      begin
         dv = (k == 0) ? 4 : 1;
         cfg = (k == 0) ? 8'h00 : (k == 1) ? 8'h02 : 8'h43;
         d = 8'hA5;
         if (cfg[C1_PEN])
            d[7] = ^d[6:0] ^ cfg[C1_PTY];
         wr(IDX_BAUD_LOW, dv[7:0]);
         u_node.bit_cyc = 32 * dv;
         wr(IDX_CTRL_ONE, cfg);
         wr(IDX_DATA_LOW, 8'hA5);
         u_node.grab(f);
         chk("tx_frame", f, {1'b1, d, 1'b0});
      end
   endtask

   task automatic t_sleep;
      wr(IDX_CTRL_ONE, 8'h00);
      fork
         begin
            u_node.send(9'h000, 8);
            u_node.send(9'h000, 8);
            u_node.send(9'h000, 8);
         end
         begin
            repeat (64) @(posedge clk);
            wr(IDX_CTRL_TWO, 8'h06);
         end
      join
      poll(IDX_STAT_ONE, 8'h3F, 8'h00, 1, "asleep_flags");
      poll(IDX_STAT_TWO, 8'h01, 8'h00, 1, "asleep_active");
      poll(IDX_CTRL_TWO, 8'h02, 8'h02, 1, "still_asleep");
      poll(IDX_CTRL_TWO, 8'h02, 8'h00, 400, "idle_wake");
      wr(IDX_CTRL_TWO, 8'h24);
      u_node.send(9'h05A, 8);
      poll(IDX_STAT_ONE, 8'h20, 8'h20, 100, "rx_full");
      irq_is(1'b1, "rx_irq");
      poll(IDX_DATA_LOW, 8'hFF, 8'h5A, 1, "rx_data");
      poll(IDX_STAT_ONE, 8'h20, 8'h00, 1, "rx_clear");
      irq_is(1'b0, "rx_irq_off");
      wr(IDX_CTRL_TWO, 8'h14);
      poll(IDX_STAT_ONE, 8'h10, 8'h10, 400, "idle_flag");
      irq_is(1'b1, "idle_irq");
   endtask

   task automatic t_addr;
      wr(IDX_CTRL_ONE, 8'h0C);
      wr(IDX_CTRL_TWO, 8'h06);
      u_node.send(9'h012, 8);
      repeat (12 * 32) @(posedge clk);
      poll(IDX_CTRL_TWO, 8'h02, 8'h02, 1, "addr_sleep");
      poll(IDX_STAT_ONE, 8'h20, 8'h00, 1, "addr_quiet");
      u_node.send(9'h092, 8);
      poll(IDX_STAT_ONE, 8'h20, 8'h20, 100, "addr_full");
      poll(IDX_CTRL_TWO, 8'h02, 8'h00, 1, "addr_wake");
      poll(IDX_DATA_LOW, 8'hFF, 8'h92, 1, "addr_data");
      poll(IDX_STAT_ONE, 8'h10, 8'h10, 400, "long_idle");
   endtask

   task automatic t_loop;
      wr(IDX_CTRL_ONE, 8'h90);
      wr(IDX_CTRL_TWO, 8'h0C);
      wr(IDX_DATA_HIGH, 8'h80);
      wr(IDX_DATA_LOW, 8'h3C);
      poll(IDX_STAT_ONE, 8'h20, 8'h20, 400, "loop_full");
      poll(IDX_DATA_HIGH, 8'h80, 8'h80, 1, "loop_ninth");
      poll(IDX_DATA_LOW, 8'hFF, 8'h3C, 1, "loop_data");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      bad_count++;
      wrap_up;
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_irq;
      t_tx;
      t_sleep;
      t_addr;
      t_loop;
      wrap_up;
   end
endmodule
